// [src/asrc_pkg.sv]
// Shared constants and types for the asynchronous static memory host controller.
package asrc_pkg;

    // ****************************************************************
    // Widths and clock.
    // ****************************************************************
    localparam int ADDR_W        = 13;
    localparam int DATA_W        = 8;
    localparam int CNT_W         = 5;
    localparam int GRADE_W       = 2;
    localparam int CLK_PERIOD_NS = 10;

    // ****************************************************************
    // Device timing in nanoseconds, one entry per speed grade 70/85/150/200; release and recovery times are single figures.
    // ****************************************************************
    localparam int SELECT_ACCESS_DELAY_NS [4] = '{70, 85, 150, 200};
    localparam int OUTPUT_ENABLE_ACCESS_NS[4] = '{35, 45, 70, 90};
    localparam int SELECT_TO_WRITE_END_NS [4] = '{65, 75, 100, 150};
    localparam int ADDRESS_TO_WRITE_END_NS[4] = '{65, 75, 90, 150};
    localparam int WRITE_PULSE_WIDTH_NS   [4] = '{55, 65, 90, 130};
    localparam int DATA_SETUP_WRITE_END_NS[4] = '{30, 35, 50, 70};
    localparam int CYCLE_TIME_NS          [4] = '{70, 85, 150, 200};
    localparam int RELEASE_DELAY_NS           = 25;
    localparam int WRITE_RECOVERY_SELECT_NS   = 15;
    localparam int WRITE_RECOVERY_STROBE_NS   = 5;

    // Least times round up to whole clock cycles.
    function automatic int ns_to_cyc(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    // The write low phase must satisfy select, address, pulse and data setup at once.
    function automatic int write_low_ns(input int g);
        int m;
        m = SELECT_TO_WRITE_END_NS[g];
        if (ADDRESS_TO_WRITE_END_NS[g] > m) m = ADDRESS_TO_WRITE_END_NS[g];
        if (WRITE_PULSE_WIDTH_NS[g] > m) m = WRITE_PULSE_WIDTH_NS[g];
        if (DATA_SETUP_WRITE_END_NS[g] > m) m = DATA_SETUP_WRITE_END_NS[g];
        return m;
    endfunction

    localparam int RELEASE_CYC  = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = (WRITE_RECOVERY_SELECT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

    // ****************************************************************
    // Sequencer states.
    // ****************************************************************
    typedef enum logic [2:0] {
        ASRC_IDLE,
        ASRC_RD_ACCESS,
        ASRC_RD_RELEASE,
        ASRC_WR_SETUP,
        ASRC_WR_PULSE,
        ASRC_WR_END,
        ASRC_RECOVER
    } asrc_state_t;

endpackage

// [src/asrc_timer.sv]
// Down counter that times each phase of a memory cycle.
`timescale 1ns/1ps
module asrc_timer (
    // Clock and reset.
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Load strobe and value.
    input  wire logic                        load,
    input  wire logic [asrc_pkg::CNT_W-1:0]  load_value,
    // Expiry flag.
    output logic                             done
);
    import asrc_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } asrc_timer_t;

    asrc_timer_t tmr_reg;
    asrc_timer_t tmr_next;

    // Load wins over counting; the counter parks at zero.
    always_comb begin
        tmr_next = tmr_reg;
        if (load) begin
            tmr_next.count = load_value;
        end else if (tmr_reg.count != '0) begin
            tmr_next.count = tmr_reg.count - CNT_W'(1);
        end
    end

    // State register.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done = (tmr_reg.count == '0);
endmodule

// [src/asrc_ctrl.sv]
// Host controller that runs read and write cycles on an asynchronous static memory.
`timescale 1ns/1ps

// Contract
// RL1: Write strobe held high during reads.
// RL2: Device stores while select and strobe low.
// RL3: Write ends at first rising control.
// RL4: Address changes only with select/strobe high.
// RL5: Select falling with strobe keeps outputs floating.
// RL6: Output enable high means device floats.
// RL7: Host never drives while output enable low.
// RL8: Read data valid after select access.
// RL9: Read data valid after enable access.
// RL10: Device outputs not early from float.
// RL11: Device floats 25 ns after select rises.
// RL12: Device floats 25 ns after enable rises.
// RL13: Previous read data held 10 ns.
// RL14: Address stable before write end per grade.
// RL15: Select low long enough before write end.
// RL16: Zero address setup, minimum write pulse.
// RL17: Write data set up before write end.
// RL18: Recovery time after every write.
// RL19: Device floats after strobe falls.
// RL20: Device re-drives no sooner than 5 ns.
// RL21: Cycles spaced by the grade's cycle time.
// RL22: Write data held until write ends.
module asrc_ctrl (
    // Clock and reset.
    input  wire logic                          mclk,
    input  wire logic                          rst,
    // Request port.
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic                          req_write,
    input  wire logic [asrc_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [asrc_pkg::DATA_W-1:0]   req_wdata,
    input  wire logic [asrc_pkg::GRADE_W-1:0]  speed_grade,
    // Read answer.
    output logic                               rd_valid,
    output logic [asrc_pkg::DATA_W-1:0]        rd_data,
    // Memory pins.
    output logic [asrc_pkg::ADDR_W-1:0]        address_in,
    output logic                               select_n,
    output logic                               output_enable_n,
    output logic                               write_strobe_n,
    input  wire logic [asrc_pkg::DATA_W-1:0]   data_io_i,
    output logic [asrc_pkg::DATA_W-1:0]        data_io_o,
    output logic                               data_io_oe
);
    import asrc_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        asrc_state_t         st;
        logic [GRADE_W-1:0]  grade;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W-1:0]   rdata;
        logic                rd_valid;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                dq_oe;
    } asrc_ctrl_t;

    asrc_ctrl_t s_reg;
    asrc_ctrl_t s_next;
    logic                t_load;
    logic [CNT_W-1:0]    t_value;
    logic                t_done;

    // Phase timer shared by every state.
    asrc_timer u_timer (
        .mclk       (mclk),
        .rst        (rst),
        .load       (t_load),
        .load_value (t_value),
        .done       (t_done)
    );

    // Sequencer. Loading N-1 keeps the control level for exactly N cycles.
    always_comb begin
        s_next          = s_reg;
        s_next.rd_valid = 1'b0;
        t_load          = 1'b0;
        t_value         = '0;
        case (s_reg.st)
            ASRC_IDLE: begin
                if (req_valid) begin
                    s_next.grade = speed_grade;
                    s_next.addr  = req_addr; // Address moves only while the strobe is high, on the same edge that drops select. [RL4]
                    s_next.wdata = req_wdata;
                    s_next.ce_n  = 1'b0;
                    t_load       = 1'b1;
                    if (req_write) begin
                        // Output enable stays high so the device floats the bus. [RL6] [RL7]
                        s_next.st    = ASRC_WR_SETUP;
                        s_next.dq_oe = 1'b1;
                        t_value      = '0;
                    end else begin
                        // Select and enable fall together; strobe stays high. [RL1]
                        s_next.st   = ASRC_RD_ACCESS;
                        s_next.oe_n = 1'b0;
                        t_value     = CNT_W'(ns_to_cyc(SELECT_ACCESS_DELAY_NS[speed_grade]) - 1);
                    end
                end
            end
            ASRC_RD_ACCESS: begin
                // Wait the slower of select and enable access before sampling. [RL8] [RL9]
                if (t_done) begin
                    s_next.rdata    = data_io_i;
                    s_next.rd_valid = 1'b1;
                    s_next.ce_n     = 1'b1;
                    s_next.oe_n     = 1'b1;
                    s_next.st       = ASRC_RD_RELEASE;
                    t_load          = 1'b1;
                    t_value         = CNT_W'(RELEASE_CYC - 1);
                end
            end
            ASRC_RD_RELEASE: begin
                // The device may drive for 25 ns more; nothing else may start. [RL11] [RL12]
                if (t_done) begin
                    s_next.st = ASRC_IDLE;
                end
            end
            ASRC_WR_SETUP: begin
                // Address and data settled one cycle before the strobe falls. [RL16]
                s_next.we_n = 1'b0; // Write begins at this later falling edge. [RL2] [RL5]
                s_next.st   = ASRC_WR_PULSE;
                t_load      = 1'b1;
                t_value     = CNT_W'(ns_to_cyc(write_low_ns(s_reg.grade)) - 1);
            end
            ASRC_WR_PULSE: begin
                // Strobe rises first, so it marks the end of the write. [RL3] [RL14] [RL15] [RL17]
                if (t_done) begin
                    s_next.we_n = 1'b1;
                    s_next.st   = ASRC_WR_END;
                end
            end
            ASRC_WR_END: begin
                // Data held one cycle past the strobe edge before letting go. [RL22]
                s_next.ce_n  = 1'b1;
                s_next.dq_oe = 1'b0;
                s_next.st    = ASRC_RECOVER;
                t_load       = 1'b1;
                t_value      = CNT_W'(RECOVERY_CYC - 1);
            end
            ASRC_RECOVER: begin
                // Recovery covers the longer select-ended figure as well. [RL18] [RL21]
                if (t_done) begin
                    s_next.st = ASRC_IDLE;
                end
            end
            default: begin
                s_next = '0;
                s_next.ce_n = 1'b1;
                s_next.oe_n = 1'b1;
                s_next.we_n = 1'b1;
            end
        endcase
    end

    // State register; controls idle high after reset.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg      <= '0;
            s_reg.st   <= ASRC_IDLE;
            s_reg.ce_n <= 1'b1;
            s_reg.oe_n <= 1'b1;
            s_reg.we_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Pins and answers straight from the state flops.
    assign req_ready       = (s_reg.st == ASRC_IDLE);
    assign rd_valid        = s_reg.rd_valid;
    assign rd_data         = s_reg.rdata;
    assign address_in      = s_reg.addr;
    assign select_n        = s_reg.ce_n;
    assign output_enable_n = s_reg.oe_n;
    assign write_strobe_n  = s_reg.we_n;
    assign data_io_o       = s_reg.wdata;
    assign data_io_oe      = s_reg.dq_oe;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    logic [CNT_W-1:0] we_low_cnt;
    logic [CNT_W-1:0] ce_low_cnt;
    logic [CNT_W-1:0] ce_high_cnt;

    // Helper counters of how long the strobe has been low and the select low or high.
    // The idle counter starts full and saturates, so that neither a reset nor a long idle
    // spell can pass for a short recovery.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            we_low_cnt  <= '0;
            ce_low_cnt  <= '0;
            ce_high_cnt <= '1;
        end else begin
            we_low_cnt  <= write_strobe_n ? '0 : we_low_cnt + CNT_W'(1);
            ce_low_cnt  <= select_n ? '0 : ce_low_cnt + CNT_W'(1);
            ce_high_cnt <= !select_n ? '0
                           : ((ce_high_cnt == '1) ? ce_high_cnt : ce_high_cnt + CNT_W'(1));
        end
    end

    read_strobe_high_a: assert property (@(posedge mclk) disable iff (rst) // [RL1]
        !output_enable_n |-> write_strobe_n)
        else $error("Write strobe low during a read.");

    addr_stable_wr_a: assert property (@(posedge mclk) disable iff (rst) // [RL4]
        $changed(address_in) |-> (select_n || write_strobe_n))
        else $error("Address moved while a cycle was active.");

    no_contention_a: assert property (@(posedge mclk) disable iff (rst) // [RL7]
        !output_enable_n |-> !data_io_oe)
        else $error("Host drives data while output enable is low.");

    pulse_width_a: assert property (@(posedge mclk) disable iff (rst) // [RL16]
        $rose(write_strobe_n) |->
            (32'($past(we_low_cnt)) * CLK_PERIOD_NS >= WRITE_PULSE_WIDTH_NS[s_reg.grade]))
        else $error("Write pulse too short.");

    select_to_end_a: assert property (@(posedge mclk) disable iff (rst) // [RL15]
        $rose(write_strobe_n) |->
            (32'(ce_low_cnt) * CLK_PERIOD_NS >= SELECT_TO_WRITE_END_NS[s_reg.grade]))
        else $error("Select low too briefly before write end.");

    data_held_a: assert property (@(posedge mclk) disable iff (rst) // [RL17]
        (!write_strobe_n && !select_n) |-> data_io_oe && $stable(data_io_o))
        else $error("Write data not stable during the write.");

    data_hold_end_a: assert property (@(posedge mclk) disable iff (rst) // [RL22]
        $rose(write_strobe_n) |-> data_io_oe ##1 $rose(select_n))
        else $error("Write data released before write end.");

    recovery_a: assert property (@(posedge mclk) disable iff (rst) // [RL18]
        $rose(select_n) |-> select_n [*2])
        else $error("Recovery after a cycle too short.");

    read_sample_a: assert property (@(posedge mclk) disable iff (rst) // [RL8]
        $rose(rd_valid) |->
            (32'($past(ce_low_cnt)) + 1) * CLK_PERIOD_NS
                >= SELECT_ACCESS_DELAY_NS[s_reg.grade])
        else $error("Read sampled before access time.");

    cycle_space_a: assert property (@(posedge mclk) disable iff (rst) // [RL21]
        $fell(select_n) |-> 32'($past(ce_high_cnt)) >= RECOVERY_CYC)
        else $error("Cycles spaced too closely.");

    read_cycle_c:  cover property (@(posedge mclk) disable iff (rst) $rose(rd_valid));
    write_cycle_c: cover property (@(posedge mclk) disable iff (rst) $rose(write_strobe_n));
    slow_grade_c:  cover property (@(posedge mclk) disable iff (rst)
        $rose(write_strobe_n) && (s_reg.grade == GRADE_W'(3)));
endmodule

// [verification/asrc_sram_model.sv]
// Behavioural pin model of the asynchronous static memory on the far side.
`timescale 1ns/1ps
module asrc_sram_model (
    // Memory pins.
    input  wire logic [asrc_pkg::ADDR_W-1:0]  address_in,
    input  wire logic                         select_n,
    input  wire logic                         output_enable_n,
    input  wire logic                         write_strobe_n,
    input  wire logic [asrc_pkg::DATA_W-1:0]  data_io,
    // Speed grade and answer mode.
    input  wire logic [asrc_pkg::GRADE_W-1:0] grade,
    input  wire logic                         slow,
    // Device drive onto the data pins.
    output logic      [asrc_pkg::DATA_W-1:0]  dev_q,
    output logic                              dev_oe
);
    import asrc_pkg::*;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    realtime           t_sel = 0.0, t_oe = 0.0, t_addr = 0.0, t_wend = 0.0, t_end = -100.0;
    int                acc, oe_acc, flt;
    logic              active;

    // Edge times that the output timing is measured from.
    always @(negedge select_n) t_sel = $realtime;
    always @(negedge output_enable_n) t_oe = $realtime;
    always @(address_in) t_addr = $realtime;

    // A write stores at the first rising control of the low overlap.
    always @(posedge write_strobe_n) begin
        if (!select_n) mem[address_in] = data_io;
        t_wend = $realtime;
    end
    always @(posedge select_n) begin
        if (!write_strobe_n) mem[address_in] = data_io;
    end

    // Output stage, stepped off the clock edges; slow mode answers just inside the limits.
    initial begin
        dev_q = 8'h00;
        dev_oe = 1'b0;
        #0.3;
        forever begin
            acc = slow ? SELECT_ACCESS_DELAY_NS[grade] - 1 : SELECT_ACCESS_DELAY_NS[grade] / 2;
            oe_acc = slow ? OUTPUT_ENABLE_ACCESS_NS[grade] - 1 : OUTPUT_ENABLE_ACCESS_NS[grade] / 2;
            flt = slow ? RELEASE_DELAY_NS - 1 : 0;
            active = !select_n && !output_enable_n && write_strobe_n
                     && ($realtime - t_sel >= 5) && ($realtime - t_wend >= 5);
            if (active) t_end = $realtime;
            dev_oe = active || ($realtime - t_end < flt);
            if (active && $realtime - t_sel >= acc && $realtime - t_oe >= oe_acc
                && $realtime - t_addr >= acc) begin
                dev_q = mem[address_in];
            end else if ($realtime - t_addr >= 10) begin
                dev_q = ~mem[address_in];
            end
            #1;
        end
    end
endmodule

// [verification/async_sram_read_write_timing_test.sv]
// Self-checking bench for the static memory host controller.
`timescale 1ns/1ps
module async_sram_read_write_timing_test;
    import asrc_pkg::*;
    typedef struct packed {
        logic               wr;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
        logic [GRADE_W-1:0] grade;
    } asrc_row_t;

    logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, req_write = 1'b0, slow = 1'b0;
    logic [ADDR_W-1:0] req_addr = 13'h0000, address_in;
    logic [DATA_W-1:0] req_wdata = 8'h00, rd_data, data_io_i, data_io_o, dev_q, bus_last;
    logic [GRADE_W-1:0] speed_grade = 2'h0, mon_grade, op_grade;
    logic rd_valid, select_n, output_enable_n, write_strobe_n, data_io_oe, dev_oe, prev_we, prev_sel;
    logic [ADDR_W-1:0] prev_addr;
    int err_count = 0, total_checks = 0, we_low, sel_low, since_fall, since_rise, pass;
    asrc_row_t rows [10] = '{
        '{1'b1, 13'h0000, 8'ha5, 2'h0}, '{1'b1, 13'h1fff, 8'h5a, 2'h1},
        '{1'b1, 13'h0aaa, 8'h00, 2'h2}, '{1'b1, 13'h1555, 8'hff, 2'h3},
        '{1'b0, 13'h0000, 8'ha5, 2'h3}, '{1'b0, 13'h1fff, 8'h5a, 2'h2},
        '{1'b0, 13'h0aaa, 8'h00, 2'h1}, '{1'b0, 13'h1555, 8'hff, 2'h0},
        '{1'b1, 13'h0aaa, 8'h3c, 2'h0}, '{1'b0, 13'h0aaa, 8'h3c, 2'h2}};

    asrc_ctrl dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .speed_grade(speed_grade), .rd_valid(rd_valid), .rd_data(rd_data),
        .address_in(address_in), .select_n(select_n), .output_enable_n(output_enable_n),
        .write_strobe_n(write_strobe_n), .data_io_i(data_io_i), .data_io_o(data_io_o),
        .data_io_oe(data_io_oe));
    asrc_sram_model mem_model (.address_in(address_in), .select_n(select_n),
        .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n), .data_io(data_io_i),
        .grade(speed_grade), .slow(slow), .dev_q(dev_q), .dev_oe(dev_oe));

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    always #5 mclk = ~mclk;

    task automatic fail(input string msg);
        err_count++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) fail(msg);
    endtask
    function automatic int cyc(input int ns);
        return (ns + 9) / 10;
    endfunction
    // The strobe must cover select, address, pulse and data setup minimums alike.
    function automatic int wlow(input int g);
        int m;
        m = SELECT_TO_WRITE_END_NS[g];
        m = (ADDRESS_TO_WRITE_END_NS[g] > m) ? ADDRESS_TO_WRITE_END_NS[g] : m;
        m = (WRITE_PULSE_WIDTH_NS[g] > m) ? WRITE_PULSE_WIDTH_NS[g] : m;
        m = (DATA_SETUP_WRITE_END_NS[g] > m) ? DATA_SETUP_WRITE_END_NS[g] : m;
        return cyc(m);
    endfunction

    // Called just after a rising edge; returns just after the taking edge or read end.
    task automatic do_op(input asrc_row_t r);
        int k;
        req_valid <= 1'b1;
        req_write <= r.wr;
        req_addr <= r.addr;
        req_wdata <= r.data;
        speed_grade <= r.grade;
        k = 0;
        do begin @(negedge mclk); k++; end while (req_ready !== 1'b1 && k < 40);
        if (k >= 40) fail("request never taken");
        @(posedge mclk);
        if (!r.wr) begin
            req_valid <= 1'b0;
            k = 0;
            do begin @(posedge mclk); k++; @(negedge mclk); end while (rd_valid !== 1'b1 && k < 40);
            chk(k == cyc(SELECT_ACCESS_DELAY_NS[r.grade]), "read answer latency");
            chk(rd_data === r.data, "read data");
            @(negedge mclk);
            chk(rd_valid === 1'b0, "read answer pulse");
            @(posedge mclk);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bus resolution; a released bus shows a changing pattern, not the last value.
    // It steps half a nanosecond after the memory model, so it never races the model.
    initial begin
        data_io_i = 8'h00;
        bus_last = 8'h00;
        #0.8;
        forever begin
            if (data_io_oe === 1'b1 && dev_oe) fail("both ends drive the data pins");
            data_io_i = (data_io_oe === 1'b1) ? data_io_o : (dev_oe ? dev_q : ~bus_last);
            bus_last = data_io_i;
            #1;
        end
    end

    // Pin monitor; sees the values that stood during the cycle before each edge.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            we_low <= 0;
            sel_low <= 0;
            since_fall <= 1000;
            since_rise <= 1000;
            prev_we <= 1'b1;
            prev_sel <= 1'b1;
            prev_addr <= 13'h0000;
        end else begin
            if (req_valid && req_ready) mon_grade <= speed_grade;
            if (!output_enable_n) chk(write_strobe_n === 1'b1, "strobe low in a read");
            if (!write_strobe_n) chk(!select_n && data_io_oe, "strobe without select or data");
            if (!select_n && !prev_sel) chk(address_in === prev_addr, "address moved");
            if (write_strobe_n && !prev_we) begin
                chk(we_low == wlow(mon_grade), "write pulse length");
                chk(sel_low >= cyc(SELECT_TO_WRITE_END_NS[mon_grade]), "select to end");
            end
            if (!select_n && prev_sel) begin
                chk(since_fall >= cyc(CYCLE_TIME_NS[op_grade]), "cycle spacing");
                chk(since_rise >= cyc(WRITE_RECOVERY_SELECT_NS), "recovery");
                op_grade <= mon_grade;
            end
            we_low <= !write_strobe_n ? we_low + 1 : 0;
            sel_low <= !select_n ? sel_low + 1 : 0;
            since_fall <= (!select_n && prev_sel) ? 1 : since_fall + 1;
            since_rise <= (select_n && !prev_sel) ? 1 : since_rise + 1;
            prev_we <= write_strobe_n;
            prev_sel <= select_n;
            prev_addr <= address_in;
        end
    end

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        #200_000;
        fail("watchdog expired");
        end_sim();
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Each table pass runs back-to-back writes and every grade, prompt then slow.
        for (pass = 0; pass < 2; pass++) begin
            slow <= pass[0];
            foreach (rows[i]) do_op(rows[i]);
        end
        // Reset in the middle of a write must drop every control at once.
        do_op('{1'b1, 13'h0555, 8'h81, 2'h3});
        req_valid <= 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b1;
        @(negedge mclk);
        chk(select_n === 1'b1 && write_strobe_n === 1'b1 && output_enable_n === 1'b1,
            "controls idle in reset");
        chk(data_io_oe === 1'b0 && req_ready === 1'b1, "bus released in reset");
        // Two edges in reset, so no sampled history from before the reset survives it.
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        do_op('{1'b0, 13'h1fff, 8'h5a, 2'h0});
        end_sim();
    end
endmodule
